// ### logic/flhr_regs.sv
`timescale 1ns/1ps
`default_nettype none

module flhr_regs (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata_q,
  input wire logic backup_mode_pin,
  input wire logic two_phase_select,
  input wire logic [1:0] chan_clk_tick,
  input wire logic [1:0] chan_en_set,
  input wire flhr_pkg::flhr_norm_t norm,
  input wire flhr_pkg::flhr_fault_t flt,
  output flhr_pkg::flhr_out_t cfg_q
);

  typedef struct packed {
    logic [7:0] latch_sel;
    logic [7:0] ov;
    logic [7:0] lh_cfg;
    logic [7:0] iadj1;
    logic [7:0] iadj2;
    logic [7:0] pwml1;
    logic [7:0] pwmh1;
    logic [7:0] pwml2;
    logic [7:0] pwmh2;
    logic [7:0] switch_current_limit;
    logic [7:0] limit_fault_timer;
    logic [7:0] main_fault_timer;
    logic [7:0] rdata;
    logic [1:0] latched_off;
    logic [1:0][5:0] switch_current_limit_cnt;
    logic [1:0] ift_run;
    flhr_pkg::flhr_out_t out;
  } flhr_state_t;

  flhr_state_t q;
  flhr_state_t d;

  logic tp;
  logic lh;
  logic [1:0] act;
  logic [1:0][7:0] dimming_dac_code_w;
  logic [1:0][9:0] pwm_w;
  logic [1:0][1:0] cnt_code;
  logic [1:0][1:0] ift_code;
  logic [1:0][3:0] mft_code;
  logic [1:0][5:0] ift_lim;
  logic [1:0][13:0] mft_lim;
  logic [1:0][6:0] cnt_inc;
  logic [1:0] switch_current_limit_hit;
  logic [1:0] ift_exp;
  logic [1:0] mft_exp;

  assign tp = two_phase_select;
  assign lh = backup_mode_pin;
  assign dimming_dac_code_w = {q.iadj2, q.iadj1};
  assign pwm_w = {q.pwmh2[1:0], q.pwml2, q.pwmh1[1:0], q.pwml1};
  assign reg_rdata_q = q.rdata;
  assign cfg_q = q.out;

  localparam int FLHR_LAT_SWITCH_CURRENT_LIMIT = flhr_pkg::FLHR_LAT_SWITCH_CURRENT_LIMIT;
  localparam int FLHR_SWITCH_CURRENT_LIMIT_CNT_POS = flhr_pkg::FLHR_SWITCH_CURRENT_LIMIT_CNT_POS;

  // Per-channel event counters and fault timers. Channel two's are held idle in two-phase operation.
  for (genvar k = 0; k < 2; k++) begin : g_ch
    assign act[k] = (k == 0) || !tp;
    assign cnt_code[k] = lh ? q.switch_current_limit[FLHR_SWITCH_CURRENT_LIMIT_CNT_POS + 2 * k +: 2] : norm.switch_current_limit_cnt_code[k];
    assign ift_code[k] = lh ? q.limit_fault_timer[2 * k +: 2] : norm.ift_code[k];
    assign mft_code[k] = lh ? q.main_fault_timer[flhr_pkg::FLHR_MFT_STRIDE * k +: 4] : norm.mft_code[k];
    assign ift_lim[k] = flhr_pkg::FLHR_IFT_MAX[ift_code[k]];
    assign mft_lim[k] = flhr_pkg::FLHR_MFT_MAX[mft_code[k]];
    assign cnt_inc[k] = {1'b0, q.switch_current_limit_cnt[k]} + 7'h01;
    assign switch_current_limit_hit[k] = act[k] && flt.switch_current_limit_evt[k] && cnt_inc[k] >= {1'b0, flhr_pkg::FLHR_SWITCH_CURRENT_LIMIT_THR[cnt_code[k]]};

    flhr_fault_timer #(
      .W(6)
    ) u_limit_timer (
      .core_clk(core_clk),
      .reset(reset),
      .tick(chan_clk_tick[k]),
      .run(q.ift_run[k] && act[k]),
      .limit(ift_lim[k]),
      .expire_q(ift_exp[k])
    );

    flhr_fault_timer #(
      .W(14)
    ) u_main_timer (
      .core_clk(core_clk),
      .reset(reset),
      .tick(chan_clk_tick[k]),
      .run(flt.mft_fault[k] && act[k]),
      .limit(mft_lim[k]),
      .expire_q(mft_exp[k])
    );
  end

  always_comb begin
    d = q;
    // Register writes; reserved positions are masked so they always read back zero.
    if (reg_wr) begin
      case (reg_addr)
        flhr_pkg::FLHR_ADDR_LATCH: d.latch_sel = reg_wdata;
        flhr_pkg::FLHR_ADDR_OV: d.ov = reg_wdata & flhr_pkg::FLHR_MASK_OV;
        flhr_pkg::FLHR_ADDR_CFG: d.lh_cfg = reg_wdata;
        flhr_pkg::FLHR_ADDR_IADJ1: d.iadj1 = reg_wdata;
        flhr_pkg::FLHR_ADDR_IADJ2: d.iadj2 = reg_wdata;
        flhr_pkg::FLHR_ADDR_PWML1: d.pwml1 = reg_wdata;
        flhr_pkg::FLHR_ADDR_PWMH1: d.pwmh1 = reg_wdata & flhr_pkg::FLHR_MASK_PWMH;
        flhr_pkg::FLHR_ADDR_PWML2: d.pwml2 = reg_wdata;
        flhr_pkg::FLHR_ADDR_PWMH2: d.pwmh2 = reg_wdata & flhr_pkg::FLHR_MASK_PWMH;
        flhr_pkg::FLHR_ADDR_SWITCH_CURRENT_LIMIT: d.switch_current_limit = reg_wdata;
        flhr_pkg::FLHR_ADDR_IFT: d.limit_fault_timer = reg_wdata & flhr_pkg::FLHR_MASK_IFT;
        flhr_pkg::FLHR_ADDR_MFT: d.main_fault_timer = reg_wdata;
        default: d.rdata = q.rdata;
      endcase
    end
    // Read data is captured and held until the next read; unmapped offsets return zero.
    if (reg_rd) begin
      case (reg_addr)
        flhr_pkg::FLHR_ADDR_LATCH: d.rdata = q.latch_sel;
        flhr_pkg::FLHR_ADDR_OV: d.rdata = q.ov;
        flhr_pkg::FLHR_ADDR_CFG: d.rdata = q.lh_cfg;
        flhr_pkg::FLHR_ADDR_IADJ1: d.rdata = q.iadj1;
        flhr_pkg::FLHR_ADDR_IADJ2: d.rdata = q.iadj2;
        flhr_pkg::FLHR_ADDR_PWML1: d.rdata = q.pwml1;
        flhr_pkg::FLHR_ADDR_PWMH1: d.rdata = q.pwmh1;
        flhr_pkg::FLHR_ADDR_PWML2: d.rdata = q.pwml2;
        flhr_pkg::FLHR_ADDR_PWMH2: d.rdata = q.pwmh2;
        flhr_pkg::FLHR_ADDR_SWITCH_CURRENT_LIMIT: d.rdata = q.switch_current_limit;
        flhr_pkg::FLHR_ADDR_IFT: d.rdata = q.limit_fault_timer;
        flhr_pkg::FLHR_ADDR_MFT: d.rdata = q.main_fault_timer;
        default: d.rdata = 8'h00;
      endcase
    end

    // Event counters restart after each threshold crossing.
    for (int k = 0; k < 2; k++) begin
      if (switch_current_limit_hit[k]) begin
        d.switch_current_limit_cnt[k] = 6'h00;
      end else if (act[k] && flt.switch_current_limit_evt[k]) begin
        d.switch_current_limit_cnt[k] = cnt_inc[k][5:0];
      end else if (!act[k]) begin
        d.switch_current_limit_cnt[k] = 6'h00;
      end
      // A non-latched crossing starts the limit timer; a crossing beats a same-cycle expiry.
      if (switch_current_limit_hit[k] && !q.latch_sel[FLHR_LAT_SWITCH_CURRENT_LIMIT + k]) begin
        d.ift_run[k] = 1'b1;
      end else if (ift_exp[k] || !act[k]) begin
        d.ift_run[k] = 1'b0;
      end
    end

    // Output channel c takes its settings from channel s, which is channel one in two-phase operation.
    for (int c = 0; c < 2; c++) begin
      int s;
      s = tp ? 0 : c;
      // The latch set wins over a re-enable arriving in the same cycle.
      if ((flt.uv[s] && q.latch_sel[flhr_pkg::FLHR_LAT_UV + s]) ||
          (flt.ov[s] && q.latch_sel[flhr_pkg::FLHR_LAT_OV + s]) ||
          (flt.oc[s] && q.latch_sel[flhr_pkg::FLHR_LAT_OC + s]) ||
          (switch_current_limit_hit[s] && q.latch_sel[FLHR_LAT_SWITCH_CURRENT_LIMIT + s])) begin
        d.latched_off[c] = 1'b1;
      end else if (chan_en_set[s]) begin
        d.latched_off[c] = 1'b0;
      end
      if (lh) begin
        d.out.chan_on[c] = !q.latched_off[c] && q.lh_cfg[flhr_pkg::FLHR_CFG_EN + s] &&
          dimming_dac_code_w[s] > flhr_pkg::FLHR_DIMMING_DAC_CODE_OFF_MAX;
        d.out.max_duty_en[c] = q.lh_cfg[flhr_pkg::FLHR_CFG_MAXD + s];
        d.out.series_drv_en[c] = q.lh_cfg[flhr_pkg::FLHR_CFG_PDRV + s];
        d.out.dac_code[c] = dimming_dac_code_w[s];
        d.out.pwm_width[c] = pwm_w[s];
        d.out.switch_current_limit_mv[c] = flhr_pkg::FLHR_SWITCH_CURRENT_LIMIT_MV[q.switch_current_limit[2 * s +: 2]];
      end else begin
        d.out.chan_on[c] = !q.latched_off[c] && norm.chan_en[s];
        d.out.max_duty_en[c] = norm.max_duty_en[s];
        d.out.series_drv_en[c] = norm.series_drv_en[s];
        d.out.dac_code[c] = norm.dac_code[s];
        d.out.pwm_width[c] = norm.pwm_width[s];
        d.out.switch_current_limit_mv[c] = flhr_pkg::FLHR_SWITCH_CURRENT_LIMIT_MV[norm.switch_current_limit_code[s]];
      end
      d.out.ov_scale[c] = flhr_pkg::FLHR_OV_SCALE[q.ov[flhr_pkg::FLHR_OV_STRIDE * s +: 3]];
      d.out.switch_current_limit_timeout[c] = ift_exp[s];
      d.out.mft_timeout[c] = mft_exp[s];
    end
    // Zero on the phase bit means the two internal PWM signals run half a period apart.
    d.out.pwm_antiphase = lh ? !q.lh_cfg[flhr_pkg::FLHR_CFG_PHASE] : norm.pwm_antiphase;
    d.out.pwm_internal = lh ? q.lh_cfg[flhr_pkg::FLHR_CFG_INTPWM] : norm.pwm_internal;
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      q <= '0;
      q.latch_sel <= flhr_pkg::FLHR_RST_LATCH;
      q.ov <= flhr_pkg::FLHR_RST_OV;
      q.lh_cfg <= flhr_pkg::FLHR_RST_CFG;
      q.iadj1 <= flhr_pkg::FLHR_RST_ZERO;
      q.iadj2 <= flhr_pkg::FLHR_RST_ZERO;
      q.pwml1 <= flhr_pkg::FLHR_RST_ZERO;
      q.pwmh1 <= flhr_pkg::FLHR_RST_ZERO;
      q.pwml2 <= flhr_pkg::FLHR_RST_ZERO;
      q.pwmh2 <= flhr_pkg::FLHR_RST_ZERO;
      q.switch_current_limit <= flhr_pkg::FLHR_RST_SWITCH_CURRENT_LIMIT;
      q.limit_fault_timer <= flhr_pkg::FLHR_RST_IFT;
      q.main_fault_timer <= flhr_pkg::FLHR_RST_MFT;
    end else begin
      q <= d;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  sequence s_latch_fault;
    !tp && flt.uv[0] && q.latch_sel[flhr_pkg::FLHR_LAT_UV];
  endsequence

  sequence s_reenable;
    !tp && q.latched_off[0] && chan_en_set[0] && flt.uv[0] == 1'b0 && flt.ov[0] == 1'b0 &&
      flt.oc[0] == 1'b0 && !switch_current_limit_hit[0];
  endsequence

  latch_off_a: assert property (s_latch_fault |=> q.latched_off[0] ##1 !cfg_q.chan_on[0])
    else $error("latched fault left channel on");
  reenable_a: assert property (s_reenable |=> !q.latched_off[0])
    else $error("channel enable write did not release latch");
  reserved_zero_a: assert property (q.ov[7] == 1'b0 && q.ov[3] == 1'b0 && q.pwmh1[7:2] == 6'h00 &&
    q.pwmh2[7:2] == 6'h00 && q.limit_fault_timer[7:4] == 4'h0) else $error("reserved bit stored");
  dac_off_a: assert property (lh && q.iadj1 <= flhr_pkg::FLHR_DIMMING_DAC_CODE_OFF_MAX |=> !cfg_q.chan_on[0])
    else $error("low dimming code left channel on");
  backup_en_a: assert property (lh && !q.latched_off[0] && q.lh_cfg[0] && q.iadj1 > 8'h08 |=>
    cfg_q.chan_on[0]) else $error("backup enable ignored");
  phase_sel_a: assert property (lh |=> cfg_q.pwm_antiphase == !$past(q.lh_cfg[7]))
    else $error("pwm phase wrong");
  source_sel_a: assert property (!lh |=> cfg_q.pwm_internal == $past(norm.pwm_internal))
    else $error("pwm source not from normal settings");
  ov_scale_a: assert property (q.ov[2:0] == 3'h7 |=> cfg_q.ov_scale[0] == 11'h4b0)
    else $error("overvoltage code seven scale wrong");
  two_phase_a: assert property (tp |=> cfg_q.switch_current_limit_timeout[1] == $past(ift_exp[0]) &&
    cfg_q.dac_code[1] == cfg_q.dac_code[0]) else $error("two-phase did not mirror channel one");
  count_thr_a: assert property (lh && q.switch_current_limit[5:4] == 2'b00 && flt.switch_current_limit_evt[0] |-> switch_current_limit_hit[0])
    else $error("threshold one missed");
  readback_a: assert property (reg_rd && reg_addr == flhr_pkg::FLHR_ADDR_MFT && !reg_wr |=>
    reg_rdata_q == $past(q.main_fault_timer)) else $error("main timer register readback wrong");

  // Backup option bits reach the outputs one cycle after they are sampled.
  sequence s_backup_split;
    lh && !tp;
  endsequence

  max_duty_a: assert property (s_backup_split |=>
    cfg_q.max_duty_en == $past(q.lh_cfg[5:4]))
    else $error("max duty enable not from backup set");
  series_drv_a: assert property (s_backup_split |=>
    cfg_q.series_drv_en == $past(q.lh_cfg[3:2]))
    else $error("series driver enable not from backup set");
  pulse_width_a: assert property (s_backup_split |=>
    cfg_q.pwm_width[1] == {$past(q.pwmh2[1:0]), $past(q.pwml2)})
    else $error("channel two pulse width wrong");
  limit_mv_a: assert property (s_backup_split ##0 (q.switch_current_limit[3:2] == 2'b11) |=>
    cfg_q.switch_current_limit_mv[1] == 8'hfa)
    else $error("limit code three threshold wrong");
  limit_mv_zero_a: assert property (s_backup_split ##0 (q.switch_current_limit[1:0] == 2'b00) |=>
    cfg_q.switch_current_limit_mv[0] == 8'h4b)
    else $error("limit code zero threshold wrong");
  dac_off_two_a: assert property (s_backup_split ##0 (q.iadj2 <= flhr_pkg::FLHR_DIMMING_DAC_CODE_OFF_MAX) |=>
    !cfg_q.chan_on[1])
    else $error("low dimming code left channel two on");
  backup_en_two_a: assert property (s_backup_split ##0 (!q.latched_off[1] && q.lh_cfg[1] &&
    q.iadj2 > flhr_pkg::FLHR_DIMMING_DAC_CODE_OFF_MAX) |=> cfg_q.chan_on[1])
    else $error("backup enable ignored on channel two");
  backup_src_a: assert property (lh |=>
    cfg_q.pwm_internal == $past(q.lh_cfg[6]))
    else $error("pwm source not from backup set");

  // Outside backup mode the normal settings drive the channel.
  normal_set_a: assert property (!lh && !tp && !q.latched_off[1] |=>
    cfg_q.chan_on[1] == $past(norm.chan_en[1]))
    else $error("normal enable not applied");
  normal_phase_a: assert property (!lh |=> cfg_q.pwm_antiphase == $past(norm.pwm_antiphase))
    else $error("normal pwm phase not applied");
  ov_code_zero_a: assert property (q.ov[2:0] == 3'h0 |=>
    cfg_q.ov_scale[0] == 11'h3e8)
    else $error("overvoltage code zero scale wrong");
  ov_seven_two_a: assert property (!tp && q.ov[6:4] == 3'h7 |=>
    cfg_q.ov_scale[1] == 11'h4b0)
    else $error("channel two overvoltage code seven scale wrong");

  // A fault whose latch select is clear never latches the channel off.
  no_select_a: assert property (!tp && !q.latched_off[0] && (q.latch_sel & 8'h55) == 8'h00 |=>
    !q.latched_off[0])
    else $error("unselected fault latched channel");

  sequence s_latch_fault_two;
    !tp && flt.ov[1] && q.latch_sel[flhr_pkg::FLHR_LAT_OV + 1];
  endsequence

  latch_off_two_a: assert property (s_latch_fault_two |=>
    q.latched_off[1] ##1 !cfg_q.chan_on[1])
    else $error("latched fault left channel two on");
  count_restart_a: assert property (switch_current_limit_hit[0] |=> q.switch_current_limit_cnt[0] == 6'h00)
    else $error("event counter did not restart");

  // In two-phase operation channel two copies channel one and its limit timer rests.
  second_timer_a: assert property (tp |=> !q.ift_run[1])
    else $error("second limit timer ran in two-phase");
  mirror_ov_a: assert property (tp |=> cfg_q.ov_scale[1] == cfg_q.ov_scale[0])
    else $error("two-phase overvoltage scale not mirrored");

  // Offsets outside the bank read back as zero.
  unmapped_zero_a: assert property (reg_rd && (reg_addr < flhr_pkg::FLHR_ADDR_LATCH ||
    reg_addr > flhr_pkg::FLHR_ADDR_MFT) |=> reg_rdata_q == 8'h00)
    else $error("unmapped offset read nonzero");

endmodule

`default_nettype wire

// ### logic/flhr_pkg.sv
package flhr_pkg;

  // Register offsets.
  localparam logic [7:0] FLHR_ADDR_LATCH = 8'h15;
  localparam logic [7:0] FLHR_ADDR_OV = 8'h16;
  localparam logic [7:0] FLHR_ADDR_CFG = 8'h17;
  localparam logic [7:0] FLHR_ADDR_IADJ1 = 8'h18;
  localparam logic [7:0] FLHR_ADDR_IADJ2 = 8'h19;
  localparam logic [7:0] FLHR_ADDR_PWML1 = 8'h1a;
  localparam logic [7:0] FLHR_ADDR_PWMH1 = 8'h1b;
  localparam logic [7:0] FLHR_ADDR_PWML2 = 8'h1c;
  localparam logic [7:0] FLHR_ADDR_PWMH2 = 8'h1d;
  localparam logic [7:0] FLHR_ADDR_SWITCH_CURRENT_LIMIT = 8'h1e;
  localparam logic [7:0] FLHR_ADDR_IFT = 8'h1f;
  localparam logic [7:0] FLHR_ADDR_MFT = 8'h20;

  // Reset values.
  localparam logic [7:0] FLHR_RST_LATCH = 8'h00;
  localparam logic [7:0] FLHR_RST_OV = 8'h22;
  localparam logic [7:0] FLHR_RST_CFG = 8'h3c;
  localparam logic [7:0] FLHR_RST_ZERO = 8'h00;
  localparam logic [7:0] FLHR_RST_SWITCH_CURRENT_LIMIT = 8'h0f;
  localparam logic [7:0] FLHR_RST_IFT = 8'h0a;
  localparam logic [7:0] FLHR_RST_MFT = 8'h99;

  // Writable bit masks; everything outside them is reserved.
  localparam logic [7:0] FLHR_MASK_OV = 8'h77;
  localparam logic [7:0] FLHR_MASK_PWMH = 8'h03;
  localparam logic [7:0] FLHR_MASK_IFT = 8'h0f;

  // Field positions (channel one; channel two sits one place higher for latch and config bits, two places higher for the count code).
  localparam int FLHR_LAT_SWITCH_CURRENT_LIMIT = 6;
  localparam int FLHR_LAT_OC = 4;
  localparam int FLHR_LAT_OV = 2;
  localparam int FLHR_LAT_UV = 0;
  localparam int FLHR_CFG_PHASE = 7;
  localparam int FLHR_CFG_INTPWM = 6;
  localparam int FLHR_CFG_MAXD = 4;
  localparam int FLHR_CFG_PDRV = 2;
  localparam int FLHR_CFG_EN = 0;
  localparam int FLHR_SWITCH_CURRENT_LIMIT_CNT_POS = 4;
  localparam int FLHR_OV_STRIDE = 4;
  localparam int FLHR_MFT_STRIDE = 4;

  // Dimming codes at or below this value turn the channel off in backup mode.
  localparam logic [7:0] FLHR_DIMMING_DAC_CODE_OFF_MAX = 8'h08;

  // Lookup tables indexed by the field code.
  localparam logic [5:0] FLHR_SWITCH_CURRENT_LIMIT_THR [4] = '{6'h01, 6'h04, 6'h10, 6'h20};
  localparam logic [7:0] FLHR_SWITCH_CURRENT_LIMIT_MV [4] = '{8'h4b, 8'h64, 8'h96, 8'hfa};
  localparam logic [5:0] FLHR_IFT_MAX [4] = '{6'h04, 6'h08, 6'h10, 6'h20};
  localparam logic [13:0] FLHR_MFT_MAX [16] = '{14'h0000, 14'h03e8, 14'h05dc, 14'h07d0, 14'h09c4, 14'h0bb8,
    14'h0dac, 14'h0fa0, 14'h1388, 14'h1770, 14'h1b58, 14'h1f40, 14'h2710, 14'h2ee0, 14'h36b0, 14'h3fff};
  // Overvoltage threshold scale in thousandths of the feedback reference.
  localparam logic [10:0] FLHR_OV_SCALE [8] = '{11'h3e8, 11'h401, 11'h41a, 11'h433, 11'h44c, 11'h465,
    11'h47e, 11'h4b0};

  typedef struct packed {
    logic [1:0] chan_en;
    logic pwm_antiphase;
    logic pwm_internal;
    logic [1:0] max_duty_en;
    logic [1:0] series_drv_en;
    logic [1:0][7:0] dac_code;
    logic [1:0][9:0] pwm_width;
    logic [1:0][1:0] switch_current_limit_code;
    logic [1:0][1:0] switch_current_limit_cnt_code;
    logic [1:0][1:0] ift_code;
    logic [1:0][3:0] mft_code;
  } flhr_norm_t;

  typedef struct packed {
    logic [1:0] uv;
    logic [1:0] ov;
    logic [1:0] oc;
    logic [1:0] switch_current_limit_evt;
    logic [1:0] mft_fault;
  } flhr_fault_t;

  typedef struct packed {
    logic [1:0] chan_on;
    logic pwm_antiphase;
    logic pwm_internal;
    logic [1:0] max_duty_en;
    logic [1:0] series_drv_en;
    logic [1:0][7:0] dac_code;
    logic [1:0][9:0] pwm_width;
    logic [1:0][7:0] switch_current_limit_mv;
    logic [1:0][10:0] ov_scale;
    logic [1:0] switch_current_limit_timeout;
    logic [1:0] mft_timeout;
  } flhr_out_t;

endpackage

// ### logic/flhr_fault_timer.sv
`timescale 1ns/1ps
`default_nettype none

// Counts channel clock ticks while run is high and pulses expire_q in the cycle after the tick that reaches limit.
module flhr_fault_timer #(
  parameter int unsigned W = 6
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic tick,
  input wire logic run,
  input wire logic [W-1:0] limit,
  output logic expire_q
);

  typedef enum logic [2:0] {
    FLHR_T_IDLE = 3'b001,
    FLHR_T_RUN = 3'b010,
    FLHR_T_DONE = 3'b100
  } flhr_tstate_t;

  typedef struct packed {
    flhr_tstate_t st;
    logic [W-1:0] cnt;
    logic expire;
  } flhr_timer_t;

  flhr_timer_t q;
  flhr_timer_t d;
  logic [W-1:0] cnt_inc;

  assign cnt_inc = q.cnt + W'(1);
  assign expire_q = q.expire;

  always_comb begin
    d = q;
    d.expire = 1'b0;
    case (q.st)
      FLHR_T_IDLE: begin
        d.cnt = '0;
        // A zero limit means the timer is disabled and never starts.
        if (run && limit != '0) begin
          d.st = FLHR_T_RUN;
        end
      end
      FLHR_T_RUN: begin
        if (!run) begin
          d.st = FLHR_T_IDLE;
          d.cnt = '0;
        end else if (tick) begin
          if (cnt_inc == limit) begin
            d.expire = 1'b1;
            d.st = FLHR_T_DONE;
          end else begin
            d.cnt = cnt_inc;
          end
        end
      end
      FLHR_T_DONE: begin
        // Holding here until run drops keeps one fault episode to one expiry.
        if (!run) begin
          d.st = FLHR_T_IDLE;
          d.cnt = '0;
        end
      end
      default: begin
        d.st = FLHR_T_IDLE;
        d.cnt = '0;
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      q <= '{st: FLHR_T_IDLE, cnt: '0, expire: 1'b0};
    end else begin
      q <= d;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  sequence s_last_tick;
    q.st == FLHR_T_RUN && run && tick && cnt_inc == limit;
  endsequence

  timer_hit_a: assert property (s_last_tick |=> expire_q ##1 !expire_q) else $error("timer missed its limit");
  count_bound_a: assert property (q.st == FLHR_T_RUN |-> q.cnt < limit) else $error("timer count above limit");
  timer_off_a: assert property (limit == '0 && q.st == FLHR_T_IDLE |=> q.st == FLHR_T_IDLE)
    else $error("disabled timer started");

endmodule

`default_nettype wire

// ### tb/flhr_host_model.sv
`timescale 1ns/1ps
`default_nettype none

// Host side of the register port. Every request changes just after a rising edge and is held over one edge.
module flhr_host_model (
  input wire logic core_clk,
  input wire logic [7:0] reg_rdata_q,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic [1:0] chan_en_set
);
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    chan_en_set = 2'h0;
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge core_clk);
    #1;
    reg_wr = 1'b0;
    // Released data shows its inverse so that a late sample cannot match by accident.
    reg_wdata = ~d;
    // One idle edge between requests keeps the strobe low for a full cycle.
    @(posedge core_clk);
    #1;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge core_clk);
    #1;
    reg_rd = 1'b0;
    reg_addr = ~a;
    @(posedge core_clk);
    #1;
    d = reg_rdata_q;
  endtask

  task automatic enable_channel(input int ch);
    chan_en_set[ch] = 1'b1;
    @(posedge core_clk);
    #1;
    chan_en_set = 2'h0;
  endtask
endmodule

`default_nettype wire

// ### tb/flhr_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("[ERR] %0t got %0h expected %0h", $time, got, exp); end end

module fault_latch_and_limp_home_registers_tb_top;
  logic core_clk, reset, reg_wr, reg_rd, backup_mode_pin, two_phase_select;
  logic [7:0] reg_addr, reg_wdata, reg_rdata_q, d, v;
  logic [1:0] chan_clk_tick, chan_en_set;
  flhr_pkg::flhr_norm_t norm;
  flhr_pkg::flhr_fault_t flt;
  flhr_pkg::flhr_out_t cfg_q;
  logic [7:0] r [12];
  int n_mismatch = 0, n_compared = 0, n_ift = 0, n_mft0 = 0, n_mft1 = 0, seed = 25, i;
  localparam logic [7:0] RST [12] = '{8'h00, 8'h22, 8'h3c, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h0f, 8'h0a, 8'h99};

  flhr_host_model i_flhr_host_model (.core_clk(core_clk), .reg_rdata_q(reg_rdata_q), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .chan_en_set(chan_en_set));

  flhr_regs i_flhr_regs (.core_clk(core_clk), .reset(reset), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q), .backup_mode_pin(backup_mode_pin),
    .two_phase_select(two_phase_select), .chan_clk_tick(chan_clk_tick), .chan_en_set(chan_en_set),
    .norm(norm), .flt(flt), .cfg_q(cfg_q));

  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  always @(negedge core_clk) begin
    if (cfg_q.switch_current_limit_timeout[0] === 1'b1) n_ift++;
    if (cfg_q.mft_timeout[0] === 1'b1) n_mft0++;
    if (cfg_q.mft_timeout[1] === 1'b1) n_mft1++;
  end

  function automatic logic [7:0] mask_of(input int k);
    case (k)
      1: return 8'h77;
      6, 8: return 8'h03;
      10: return 8'h0f;
      default: return 8'hff;
    endcase
  endfunction

  function automatic logic [10:0] ovs(input logic [2:0] c);
    return (c == 3'h7) ? 11'h4b0 : 11'h3e8 + 11'h019 * {8'h00, c};
  endfunction

  function automatic logic [7:0] mv(input logic [1:0] c);
    case (c)
      2'h0: return 8'h4b;
      2'h1: return 8'h64;
      2'h2: return 8'h96;
      default: return 8'hfa;
    endcase
  endfunction

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic wreg(input int k, input logic [7:0] val);
    i_flhr_host_model.wr(8'h15 + 8'(k), val);
    r[k] = val & mask_of(k);
  endtask

  task automatic tick(input logic [1:0] m, input int n);
    chan_clk_tick = m;
    cyc(n);
    chan_clk_tick = 2'h0;
  endtask

  task automatic pulse(input int k, input int ch);
    flhr_pkg::flhr_fault_t f;
    f = '0;
    case (k)
      0: f.uv[ch] = 1'b1;
      1: f.ov[ch] = 1'b1;
      2: f.oc[ch] = 1'b1;
      default: f.switch_current_limit_evt[ch] = 1'b1;
    endcase
    flt = f;
    cyc(1);
    flt = '0;
    cyc(1);
  endtask

  task automatic chk_backup();
    `CHK(cfg_q.chan_on, r[2][1:0] & {r[4] > 8'h08, r[3] > 8'h08})
    `CHK(cfg_q.pwm_antiphase, ~r[2][7])
    `CHK(cfg_q.pwm_internal, r[2][6])
    `CHK(cfg_q.max_duty_en, r[2][5:4])
    `CHK(cfg_q.series_drv_en, r[2][3:2])
    `CHK(cfg_q.dac_code, {r[4], r[3]})
    `CHK(cfg_q.pwm_width, {r[8][1:0], r[7], r[6][1:0], r[5]})
    `CHK(cfg_q.switch_current_limit_mv, {mv(r[9][3:2]), mv(r[9][1:0])})
    `CHK(cfg_q.ov_scale, {ovs(r[1][6:4]), ovs(r[1][2:0])})
  endtask

  task automatic tally_and_finish();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge core_clk);
    n_mismatch++;
    tally_and_finish();
  end

  initial begin
    reset = 1'b1;
    backup_mode_pin = 1'b0;
    two_phase_select = 1'b0;
    chan_clk_tick = 2'h0;
    norm = '0;
    flt = '0;
    cyc(16);
    reset = 1'b0;
    for (i = 0; i < 12; i++) begin
      r[i] = RST[i];
      i_flhr_host_model.rd(8'h15 + 8'(i), d);
      `CHK(d, RST[i])
    end
    i_flhr_host_model.wr(8'h14, 8'hff);
    i_flhr_host_model.wr(8'h21, 8'hff);
    i_flhr_host_model.rd(8'h14, d);
    `CHK(d, 8'h00)
    i_flhr_host_model.rd(8'h21, d);
    `CHK(d, 8'h00)
    for (i = 0; i < 52; i++) begin
      v = (i < 12) ? 8'hff : 8'($random(seed));
      wreg((i < 12) ? i : $unsigned($random(seed)) % 12, v);
      i_flhr_host_model.rd(8'h15 + 8'(i % 12), d);
      `CHK(d, r[i % 12])
    end
    backup_mode_pin = 1'b1;
    cyc(3);
    chk_backup();
    norm = {$random(seed), $random(seed)};
    backup_mode_pin = 1'b0;
    cyc(3);
    `CHK(cfg_q.chan_on, norm.chan_en)
    `CHK(cfg_q.dac_code, norm.dac_code)
    `CHK(cfg_q.pwm_width, norm.pwm_width)
    `CHK(cfg_q.pwm_internal, norm.pwm_internal)
    `CHK(cfg_q.switch_current_limit_mv[0], mv(norm.switch_current_limit_code[0]))
    `CHK(cfg_q.ov_scale[1], ovs(r[1][6:4]))
    backup_mode_pin = 1'b1;
    wreg(4, 8'hff);
    wreg(9, 8'h0f);
    for (i = 0; i < 8; i++) begin
      wreg(1, 8'(i * 17));
      wreg(2, {i[1:0], 6'h03});
      wreg(3, 8'h08 + 8'(i % 4));
      cyc(3);
      chk_backup();
    end
    for (i = 0; i < 8; i++) begin
      wreg(0, 8'h00);
      pulse(i / 2, i % 2);
      cyc(3);
      `CHK(cfg_q.chan_on, 2'h3)
      wreg(0, 8'h01 << i);
      pulse(i / 2, i % 2);
      cyc(3);
      `CHK(cfg_q.chan_on, 2'h3 ^ 2'(1 << (i % 2)))
      i_flhr_host_model.enable_channel(i % 2);
      cyc(3);
      `CHK(cfg_q.chan_on, 2'h3)
    end
    two_phase_select = 1'b1;
    wreg(2, 8'h01);
    wreg(3, 8'h20);
    wreg(4, 8'h00);
    wreg(0, 8'h0c);
    cyc(3);
    `CHK(cfg_q.chan_on, 2'h3)
    `CHK(cfg_q.dac_code[1], 8'h20)
    pulse(1, 1);
    cyc(3);
    `CHK(cfg_q.chan_on, 2'h3)
    pulse(1, 0);
    cyc(3);
    `CHK(cfg_q.chan_on, 2'h0)
    two_phase_select = 1'b0;
    reset = 1'b1;
    cyc(16);
    reset = 1'b0;
    wreg(9, 8'h10);
    wreg(10, 8'h00);
    wreg(11, 8'h01);
    repeat (3) pulse(3, 0);
    cyc(2);
    tick(2'h1, 8);
    cyc(4);
    `CHK(n_ift, 0)
    pulse(3, 0);
    cyc(2);
    tick(2'h1, 3);
    cyc(3);
    `CHK(n_ift, 0)
    tick(2'h1, 1);
    cyc(4);
    `CHK(n_ift, 1)
    flt.mft_fault = 2'h3;
    cyc(2);
    tick(2'h3, 999);
    cyc(4);
    `CHK(n_mft0, 0)
    tick(2'h3, 1);
    cyc(4);
    `CHK(n_mft0, 1)
    `CHK(n_mft1, 0)
    flt = '0;
    tally_and_finish();
  end
endmodule

`default_nettype wire
